// *** logic/rrfse_pkg.sv ***
// Constants, types and register map for the return, flag and shift execution block
`default_nettype none
package rrfse_pkg;

  // Data path width
  localparam int unsigned XLEN = 32;

  // Instruction encodings and the masks that free their register fields
  localparam logic [15:0] ENC_ROTATE = 16'h4005;
  localparam logic [15:0] MASK_ROTATE = 16'hf0ff;
  localparam logic [15:0] ENC_ERET = 16'h002b;
  localparam logic [15:0] ENC_RTS = 16'h000b;
  localparam logic [15:0] ENC_SETS = 16'h0058;
  localparam logic [15:0] ENC_SETC = 16'h0018;
  localparam logic [15:0] ENC_ASHIFT = 16'h400c;
  localparam logic [15:0] MASK_ASHIFT = 16'hf00f;

  // Register field positions inside the instruction word
  localparam int unsigned DST_LO = 8;
  localparam int unsigned SRC_LO = 4;

  // Status word bit positions
  localparam int unsigned FLAG_CMP = 0;
  localparam int unsigned FLAG_MAC = 1;
  localparam int unsigned FLAG_PRIV = 30;
  localparam int unsigned SIGN = 31;

  // Program counter step for one sixteen bit instruction
  localparam logic [31:0] PC_STEP = 32'h0000_0002;

  // Extra busy cycles of the exception return beyond its issue cycle
  localparam logic [1:0] ERET_WAIT = 2'h3;
  localparam logic [1:0] WAIT_LAST = 2'h1;

  // Reset values
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [31:0] STW_RESET = 32'h4000_0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  // Register byte addresses on the bus
  localparam logic [7:0] ADDR_STAT = 8'h00;
  localparam logic [7:0] ADDR_CLR = 8'h04;
  localparam logic [7:0] ADDR_EN = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0c;
  localparam logic [7:0] ADDR_STW = 8'h10;
  localparam logic [7:0] ADDR_SAVST = 8'h14;
  localparam logic [7:0] ADDR_SAVPC = 8'h18;
  localparam logic [7:0] ADDR_LINK = 8'h1c;
  localparam logic [7:0] ADDR_TGT = 8'h20;
  localparam logic [1:0] GPR_WIN = 2'h1;

  // Bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Event bits: general illegal, slot illegal, delayed return completed
  localparam int unsigned NUM_EV = 3;
  typedef struct packed {
    logic retDone;
    logic slotIll;
    logic genIll;
  } rrfse_evt_t;

endpackage : rrfse_pkg
`default_nettype wire

// *** logic/rrfse_exec.sv ***
// Execution unit for rotate, returns, flag sets and dynamic arithmetic shift
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rrfse_exec (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Instruction stream
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic extSlot,
  output logic instrReady,
  output logic [31:0] pcOut,
  output logic [31:0] statusOut,
  output logic fetchPriv,
  output logic intAllow,
  output logic excGenIll,
  output logic excSlotIll,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rrfse_pkg::*;

  typedef enum {ST_RUN, ST_ERET_WAIT} rrfse_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [31:0] gpr [16]; // General registers
  logic [31:0] pcReg; // Program counter
  logic [31:0] stwReg; // Status word
  logic [31:0] savStReg; // Saved status word
  logic [31:0] savPcReg; // Saved program counter
  logic [31:0] linkReg; // Return link register
  logic [31:0] targetReg; // Pending branch target
  logic slotPendReg; // Next instruction is a delay slot
  logic eretSlotReg; // That slot belongs to an exception return
  logic fetchPrivReg; // Mode used to fetch the next instruction
  logic intAllowReg; // Interrupt may be taken now
  logic instrReadyReg; // Ready for the next instruction
  logic [1:0] waitReg; // Remaining return busy cycles
  rrfse_state_t stateReg; // Sequencer state
  logic excGenReg; // General illegal pulse
  logic excSlotReg; // Slot illegal pulse
  rrfse_evt_t statReg; // Sticky event bits
  rrfse_evt_t enReg; // Event enables
  logic irqReg; // Interrupt line

  // Bus state
  logic awreadyReg, wreadyReg, bvalidReg, arreadyReg, rvalidReg;
  logic [1:0] brespReg, rrespReg;
  logic [31:0] rdataReg;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic take; // Instruction accepted this cycle
  logic isRot, isEret, isRts, isSets, isSetc, isAsh, isBranch;
  logic inSlot; // Instruction sits in some delay slot
  logic slotIll, genIll, eretLegal, rtsLegal;
  logic [3:0] dstIdx, srcIdx;
  logic [31:0] dstVal, srcVal;

  assign take = ce && instrValid && instrReadyReg;
  assign isRot = (instrWord & MASK_ROTATE) == ENC_ROTATE;
  assign isEret = instrWord == ENC_ERET;
  assign isRts = instrWord == ENC_RTS;
  assign isSets = instrWord == ENC_SETS;
  assign isSetc = instrWord == ENC_SETC;
  assign isAsh = (instrWord & MASK_ASHIFT) == ENC_ASHIFT;
  assign isBranch = isEret || isRts;
  assign dstIdx = instrWord[DST_LO +: 4];
  assign srcIdx = instrWord[SRC_LO +: 4];
  assign dstVal = gpr[dstIdx];
  assign srcVal = gpr[srcIdx];
  // Own slot or a slot of a branch decoded elsewhere in the core
  assign inSlot = slotPendReg || extSlot;
  assign slotIll = take && inSlot && isBranch;
  assign genIll = take && !slotIll && isEret && !stwReg[FLAG_PRIV];
  assign eretLegal = take && isEret && !slotIll && !genIll;
  assign rtsLegal = take && isRts && !slotIll;

  ////////////////////////////////////////////////////////////////////////////
  // Dynamic arithmetic shift
  logic [4:0] shCnt; // Low five bits of the source
  logic [4:0] rightCnt; // Negated count, only 1 to 31 reach it
  logic [31:0] ashRes;
  always_comb begin
    shCnt = srcVal[4:0];
    rightCnt = 5'(~shCnt + 5'h01);
    if (!srcVal[SIGN]) begin
      ashRes = dstVal << shCnt;
    end else if (shCnt == 5'h00) begin
      // Thirty-two places: only the sign survives
      ashRes = {XLEN{dstVal[SIGN]}};
    end else begin
      ashRes = 32'($signed(dstVal) >>> rightCnt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus write decode
  logic wrFire; // Address and data both taken
  logic [31:0] wrMerged; // Write data merged under strobes
  logic [31:0] wrOld; // Current value of the written word
  logic wrGpr;
  logic [3:0] wrGprIdx;
  assign wrFire = awreadyReg && wreadyReg;
  assign wrGpr = s_axi_awaddr[7:6] == GPR_WIN;
  assign wrGprIdx = s_axi_awaddr[5:2];

  always_comb begin
    case (s_axi_awaddr)
      ADDR_PC: wrOld = pcReg;
      ADDR_STW: wrOld = stwReg;
      ADDR_SAVST: wrOld = savStReg;
      ADDR_SAVPC: wrOld = savPcReg;
      ADDR_LINK: wrOld = linkReg;
      ADDR_EN: wrOld = {29'h0, enReg};
      default: wrOld = wrGpr ? gpr[wrGprIdx] : ZERO32;
    endcase
    for (int b = 0; b < 4; b++) begin
      wrMerged[b*8 +: 8] = s_axi_wstrb[b] ? s_axi_wdata[b*8 +: 8] : wrOld[b*8 +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word; bus write wins over execution in the same cycle
  logic [31:0] stwNext;
  always_comb begin
    stwNext = stwReg;
    if (wrFire && s_axi_awaddr == ADDR_STW) begin
      stwNext = wrMerged;
    end else if (eretLegal) begin
      stwNext = savStReg;
    end else if (take && isRot) begin
      stwNext[FLAG_CMP] = dstVal[0];
    end else if (take && isSetc) begin
      stwNext[FLAG_CMP] = 1'b1;
    end else if (take && isSets) begin
      stwNext[FLAG_MAC] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stwReg <= STW_RESET;
    end else if (ce) begin
      stwReg <= stwNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // General registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        gpr[i] <= ZERO32;
      end
    end else if (ce) begin
      if (wrFire && wrGpr) begin
        gpr[wrGprIdx] <= wrMerged;
      end else if (take && isRot) begin
        gpr[dstIdx] <= {dstVal[0], dstVal[31:1]};
      end else if (take && isAsh) begin
        gpr[dstIdx] <= ashRes;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Saved copies and link register, loaded by software only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      savStReg <= STW_RESET;
      savPcReg <= PC_RESET;
      linkReg <= PC_RESET;
    end else if (ce && wrFire) begin
      if (s_axi_awaddr == ADDR_SAVST) savStReg <= wrMerged;
      if (s_axi_awaddr == ADDR_SAVPC) savPcReg <= wrMerged;
      if (s_axi_awaddr == ADDR_LINK) linkReg <= wrMerged;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter, delay slot tracking and branch target
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pcReg <= PC_RESET;
      targetReg <= PC_RESET;
      slotPendReg <= 1'b0;
      eretSlotReg <= 1'b0;
    end else if (ce) begin
      if (wrFire && s_axi_awaddr == ADDR_PC) begin
        // Software redirect drops any pending branch
        pcReg <= wrMerged;
        slotPendReg <= 1'b0;
        eretSlotReg <= 1'b0;
      end else if (take) begin
        if (slotIll || genIll) begin
          // Core exception logic redirects; PC keeps the faulting address
          slotPendReg <= 1'b0;
          eretSlotReg <= 1'b0;
        end else if (slotPendReg) begin
          pcReg <= targetReg;
          slotPendReg <= 1'b0;
          eretSlotReg <= 1'b0;
        end else if (rtsLegal) begin
          // Target captured now, before the slot may alter anything
          targetReg <= linkReg;
          pcReg <= pcReg + PC_STEP;
          slotPendReg <= 1'b1;
        end else if (eretLegal) begin
          targetReg <= savPcReg;
          pcReg <= pcReg + PC_STEP;
          slotPendReg <= 1'b1;
          eretSlotReg <= 1'b1;
        end else begin
          pcReg <= pcReg + PC_STEP;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Issue sequencer: the exception return holds issue for its busy cycles
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stateReg <= ST_RUN;
      waitReg <= 2'h0;
      instrReadyReg <= 1'b1;
    end else if (ce) begin
      case (stateReg)
        ST_RUN: begin
          if (eretLegal) begin
            stateReg <= ST_ERET_WAIT;
            waitReg <= ERET_WAIT;
            instrReadyReg <= 1'b0;
          end
        end
        ST_ERET_WAIT: begin
          waitReg <= waitReg - 2'h1;
          if (waitReg == WAIT_LAST) begin
            stateReg <= ST_RUN;
            instrReadyReg <= 1'b1;
          end
        end
        default: begin
          stateReg <= ST_RUN;
          instrReadyReg <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch mode and interrupt window
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fetchPrivReg <= STW_RESET[FLAG_PRIV];
      intAllowReg <= 1'b1;
    end else if (ce) begin
      // Slot of an exception return is fetched in the mode that preceded it
      if (!(eretLegal || (eretSlotReg && !take))) begin
        fetchPrivReg <= stwNext[FLAG_PRIV];
      end
      // Closed while a return waits for its slot to run
      intAllowReg <= !(eretLegal || rtsLegal ||
                       (slotPendReg && !take));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exception pulses and event status; a new event beats its clear
  logic [NUM_EV-1:0] evNow;
  assign evNow = {take && slotPendReg && !slotIll, slotIll, genIll};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      excGenReg <= 1'b0;
      excSlotReg <= 1'b0;
      statReg <= '0;
      enReg <= '0;
      irqReg <= 1'b0;
    end else if (ce) begin
      excGenReg <= genIll;
      excSlotReg <= slotIll;
      if (wrFire && s_axi_awaddr == ADDR_CLR) begin
        statReg <= (statReg & ~wrMerged[NUM_EV-1:0]) | evNow;
      end else begin
        statReg <= statReg | evNow;
      end
      if (wrFire && s_axi_awaddr == ADDR_EN) begin
        enReg <= wrMerged[NUM_EV-1:0];
      end
      irqReg <= |(statReg & enReg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus write channel: address and data taken together, then response
  logic wrMapped;
  assign wrMapped = wrGpr || (s_axi_awaddr inside
    {ADDR_STAT, ADDR_CLR, ADDR_EN, ADDR_PC, ADDR_STW, ADDR_SAVST, ADDR_SAVPC, ADDR_LINK});

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      awreadyReg <= 1'b0;
      wreadyReg <= 1'b0;
      bvalidReg <= 1'b0;
      brespReg <= RESP_OKAY;
    end else if (ce) begin
      if (wrFire) begin
        awreadyReg <= 1'b0;
        wreadyReg <= 1'b0;
        bvalidReg <= 1'b1;
        brespReg <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_awvalid && s_axi_wvalid && !bvalidReg) begin
        awreadyReg <= 1'b1;
        wreadyReg <= 1'b1;
      end
      if (bvalidReg && s_axi_bready) begin
        bvalidReg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus read channel
  logic [31:0] rdMux;
  logic rdMapped;
  always_comb begin
    rdMapped = 1'b1;
    case (s_axi_araddr)
      ADDR_STAT: rdMux = {29'h0, statReg};
      ADDR_CLR: rdMux = ZERO32; // Write-only
      ADDR_EN: rdMux = {29'h0, enReg};
      ADDR_PC: rdMux = pcReg;
      ADDR_STW: rdMux = stwReg;
      ADDR_SAVST: rdMux = savStReg;
      ADDR_SAVPC: rdMux = savPcReg;
      ADDR_LINK: rdMux = linkReg;
      ADDR_TGT: rdMux = targetReg;
      default: begin
        rdMapped = s_axi_araddr[7:6] == GPR_WIN;
        rdMux = rdMapped ? gpr[s_axi_araddr[5:2]] : ZERO32;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      arreadyReg <= 1'b0;
      rvalidReg <= 1'b0;
      rdataReg <= ZERO32;
      rrespReg <= RESP_OKAY;
    end else if (ce) begin
      if (arreadyReg) begin
        arreadyReg <= 1'b0;
        rvalidReg <= 1'b1;
        rdataReg <= rdMux;
        rrespReg <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_arvalid && !rvalidReg) begin
        arreadyReg <= 1'b1;
      end
      if (rvalidReg && s_axi_rready) begin
        rvalidReg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops
  assign instrReady = instrReadyReg;
  assign pcOut = pcReg;
  assign statusOut = stwReg;
  assign fetchPriv = fetchPrivReg;
  assign intAllow = intAllowReg;
  assign excGenIll = excGenReg;
  assign excSlotIll = excSlotReg;
  assign irq = irqReg;
  assign s_axi_awready = awreadyReg;
  assign s_axi_wready = wreadyReg;
  assign s_axi_bvalid = bvalidReg;
  assign s_axi_bresp = brespReg;
  assign s_axi_arready = arreadyReg;
  assign s_axi_rvalid = rvalidReg;
  assign s_axi_rdata = rdataReg;
  assign s_axi_rresp = rrespReg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_rotate_result: assert property (@(posedge clk_sys) disable iff (rst)
    (take && isRot && !wrFire) |=> (gpr[$past(dstIdx)] ==
      {$past(dstVal[0]), $past(dstVal[31:1])}) && (stwReg[FLAG_CMP] == $past(dstVal[0])))
    else $error("rotate result or T wrong");

  chk_eret_restore: assert property (@(posedge clk_sys) disable iff (rst)
    (eretLegal && !wrFire) |=> (stwReg == $past(savStReg)) && (targetReg == $past(savPcReg)))
    else $error("return did not restore status and target");

  chk_eret_busy: assert property (@(posedge clk_sys) disable iff (rst)
    eretLegal |=> !instrReady [*3])
    else $error("return not busy for its cycles");

  chk_eret_user: assert property (@(posedge clk_sys) disable iff (rst)
    (take && isEret && !inSlot && !stwReg[FLAG_PRIV]) |=> excGenIll && !slotPendReg)
    else $error("user mode return not trapped");

  chk_slot_target: assert property (@(posedge clk_sys) disable iff (rst)
    (take && slotPendReg && !slotIll && !wrFire) |=> pcReg == $past(targetReg))
    else $error("slot did not branch to captured target");

  chk_int_window: assert property (@(posedge clk_sys) disable iff (rst)
    (eretLegal || rtsLegal) |=> !intAllow throughout (slotPendReg [*1]))
    else $error("interrupt window open before slot");

  chk_slot_branch: assert property (@(posedge clk_sys) disable iff (rst)
    (take && inSlot && isBranch) |=> excSlotIll && !excGenIll)
    else $error("branch in slot not trapped");

  chk_fetch_mode: assert property (@(posedge clk_sys) disable iff (rst)
    eretLegal |=> fetchPriv == $past(stwReg[FLAG_PRIV]))
    else $error("slot fetch mode not the old one");

  chk_rts_target: assert property (@(posedge clk_sys) disable iff (rst)
    rtsLegal |=> slotPendReg && (targetReg == $past(linkReg)))
    else $error("subroutine return target wrong");

  chk_flag_sets: assert property (@(posedge clk_sys) disable iff (rst)
    (take && (isSets || isSetc) && !wrFire) |=> (stwReg[FLAG_MAC] || stwReg[FLAG_CMP]) &&
      (stwReg[FLAG_PRIV] == $past(stwReg[FLAG_PRIV])))
    else $error("flag set instruction wrong");

  chk_ash_right: assert property (@(posedge clk_sys) disable iff (rst)
    (take && isAsh && srcVal[SIGN] && shCnt == 5'h00 && !wrFire) |=>
      gpr[$past(dstIdx)] == {XLEN{$past(dstVal[SIGN])}})
    else $error("thirty-two place shift wrong");

  chk_ash_tflag: assert property (@(posedge clk_sys) disable iff (rst)
    (take && isAsh && !wrFire) |=> $stable(stwReg))
    else $error("shift changed the status word");

  chk_pc_step: assert property (@(posedge clk_sys) disable iff (rst)
    (take && !isBranch && !inSlot && !wrFire) |=> pcReg == $past(pcReg) + PC_STEP)
    else $error("PC did not advance by two");

endmodule : rrfse_exec
`default_nettype wire

// *** tb/tb_rrfse_exec.sv ***
// Self-checking bench for the return, flag and shift execution block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errorCnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_rrfse_exec;
  import rrfse_pkg::*;
  logic clk_sys, rst, ce, instrValid, extSlot; // Core side drives
  logic [15:0] instrWord; // Offered encoding
  logic instrReady, fetchPriv, intAllow, excGenIll, excSlotIll, irq; // Core side results
  logic [31:0] pcOut, statusOut; // Architectural state
  logic [7:0] awAddr, arAddr; // Bus addresses
  logic [31:0] wData, rData; // Bus data
  logic [1:0] bResp, rResp; // Bus responses
  logic awValid, awReady, wValid, wReady, bValid, bReady; // Write channels
  logic arValid, arReady, rValid, rReady; // Read channels
  int errorCnt, comparisons; // Verdict counters

  rrfse_exec dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .instrValid(instrValid),
    .instrWord(instrWord), .extSlot(extSlot), .instrReady(instrReady), .pcOut(pcOut),
    .statusOut(statusOut), .fetchPriv(fetchPriv), .intAllow(intAllow),
    .excGenIll(excGenIll), .excSlotIll(excSlotIll), .irq(irq),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 100 ns period
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Prints counts and verdict, then stops
  task automatic wrapUp;
    $display("comparisons=%0d errors=%0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrapUp

  // Offers one instruction and holds it until taken; stall length is not assumed
  task automatic issue(input logic [15:0] w, input logic s);
    @(posedge clk_sys);
    instrWord <= w;
    extSlot <= s;
    instrValid <= 1'b1;
    do @(posedge clk_sys); while (instrReady !== 1'b1);
    instrValid <= 1'b0;
    extSlot <= 1'b0;
    #1;
  endtask : issue

  // Bus write; each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awReady === 1'b1) awValid <= 1'b0;
      if (wReady === 1'b1) wValid <= 1'b0;
    end while (bValid !== 1'b1);
    bReady <= 1'b0;
    `CHK(bResp, RESP_OKAY)
  endtask : wr

  // Bus read compared with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge clk_sys);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arReady === 1'b1) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    rReady <= 1'b0;
    `CHK(rData, e)
    `CHK(rResp, r)
  endtask : rd

  // Dynamic shift of R2 by R3; compare flag must survive as one
  task automatic ashift(input logic [31:0] n, input logic [31:0] m, input logic [31:0] e);
    wr(8'h48, n);
    wr(8'h4c, m);
    issue(16'h423c, 1'b0);
    `CHK(statusOut[FLAG_CMP], 1'b1)
    rd(8'h48, e, RESP_OKAY);
  endtask : ashift

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog; the whole sequence needs well under a tenth of this
  initial begin
    repeat (20000) @(posedge clk_sys);
    errorCnt++;
    wrapUp();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, ce, instrValid, extSlot, instrWord} = {1'b1, 1'b1, 1'b0, 1'b0, 16'h0000};
    {awAddr, arAddr, wData} = {8'h00, 8'h00, 32'h0000_0000};
    {awValid, wValid, bReady, arValid, rReady} = 5'h00;
    errorCnt = 0;
    comparisons = 0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    `CHK(statusOut, STW_RESET)
    `CHK(pcOut, PC_RESET)
    // Rotate a one then a zero out of bit 0
    wr(8'h44, 32'h0000_0001);
    issue(16'h4105, 1'b0);
    `CHK(statusOut[FLAG_CMP], 1'b1)
    `CHK(pcOut, 32'h0000_0002)
    rd(8'h44, 32'h8000_0000, RESP_OKAY);
    issue(16'h4105, 1'b0);
    `CHK(statusOut[FLAG_CMP], 1'b0)
    rd(8'h44, 32'h4000_0000, RESP_OKAY);
    // Flag setters; everything else in the status word untouched
    issue(ENC_SETC, 1'b0);
    `CHK(statusOut, 32'h4000_0001)
    issue(ENC_SETS, 1'b0);
    `CHK(statusOut, 32'h4000_0003)
    `CHK(pcOut, 32'h0000_0008)
    // Shift directions, count edges and sign fill
    ashift(32'h8018_0000, 32'hffff_ffec, 32'hffff_f801);
    ashift(32'hffff_f801, 32'h0000_0014, 32'h8010_0000);
    ashift(32'h8000_0000, 32'h8000_0000, 32'hffff_ffff);
    ashift(32'h4000_0000, 32'h8000_0000, 32'h0000_0000);
    ashift(32'h0000_0001, 32'h0000_001f, 32'h8000_0000);
    ashift(32'h1234_5678, 32'h0000_0020, 32'h1234_5678);
    ashift(32'h8000_0000, 32'hffff_ffff, 32'hc000_0000);
    // Subroutine return; link changed before the slot must not move the target
    wr(ADDR_LINK, 32'h0000_0100);
    wr(ADDR_EN, 32'h0000_0004);
    issue(ENC_RTS, 1'b0);
    `CHK(intAllow, 1'b0)
    `CHK(pcOut, 32'h0000_0018)
    wr(ADDR_LINK, 32'h0000_0300);
    rd(ADDR_TGT, 32'h0000_0100, RESP_OKAY);
    issue(16'h0009, 1'b0);
    `CHK(pcOut, 32'h0000_0100)
    `CHK(intAllow, 1'b1)
    rd(ADDR_STAT, 32'h0000_0004, RESP_OKAY);
    `CHK(irq, 1'b1)
    wr(ADDR_CLR, 32'h0000_0004);
    rd(ADDR_STAT, 32'h0000_0000, RESP_OKAY);
    `CHK(irq, 1'b0)
    // A return sitting in a return's slot
    issue(ENC_RTS, 1'b0);
    issue(ENC_RTS, 1'b0);
    `CHK(excSlotIll, 1'b1)
    `CHK(pcOut, 32'h0000_0102)
    // Privileged exception return into user mode
    wr(ADDR_SAVST, 32'h0000_0001);
    wr(ADDR_SAVPC, 32'h0000_0200);
    issue(ENC_ERET, 1'b0);
    `CHK(statusOut, 32'h0000_0001)
    `CHK(fetchPriv, 1'b1)
    `CHK(instrReady, 1'b0)
    `CHK(intAllow, 1'b0)
    `CHK(pcOut, 32'h0000_0104)
    issue(16'h0009, 1'b0);
    `CHK(pcOut, 32'h0000_0200)
    `CHK(fetchPriv, 1'b0)
    // User mode return refused without restoring
    wr(ADDR_SAVST, 32'h4000_0000);
    issue(ENC_ERET, 1'b0);
    `CHK(excGenIll, 1'b1)
    `CHK(statusOut, 32'h0000_0001)
    `CHK(pcOut, 32'h0000_0200)
    // Exception return inside an outer delay slot
    wr(ADDR_STW, 32'h4000_0000);
    issue(ENC_ERET, 1'b1);
    `CHK(excSlotIll, 1'b1)
    `CHK(pcOut, 32'h0000_0200)
    // Event record, clear and an unmapped place
    rd(ADDR_STAT, 32'h0000_0007, RESP_OKAY);
    wr(ADDR_CLR, 32'h0000_0007);
    rd(ADDR_STAT, 32'h0000_0000, RESP_OKAY);
    rd(8'h30, 32'h0000_0000, RESP_SLVERR);
    wrapUp();
  end
endmodule : tb_rrfse_exec
`default_nettype wire
